// [hw/mrvio_defs.vh]
// Constants of the matrix routing and virtual I/O block.
// Assumes inclusion by bare name from the design files.
`ifndef MRVIO_DEFS_VH
`define MRVIO_DEFS_VH

// Select field geometry
`define MRVIO_SEL_W          6
`define MRVIO_NUM_LINES      64
`define MRVIO_OUT_FIRST      12
`define MRVIO_OUT_LAST       79
`define MRVIO_CFG_LO         72
`define MRVIO_CFG_HI         479

// Fixed matrix inputs
`define MRVIO_MI_GND         0
`define MRVIO_MI_VDD         63
`define MRVIO_MI_VIN8        22
`define MRVIO_MI_VIN9        23
`define MRVIO_MI_VIN0        24
`define MRVIO_MI_VIN7        31

// Configuration bits that hold the virtual inputs
`define MRVIO_CFG_VIN8_BIT   502
`define MRVIO_CFG_VIN9_BIT   503
`define MRVIO_CFG_VIN0_BIT   504
`define MRVIO_CFG_VIN7_BIT   511

// Matrix outputs with special handling
`define MRVIO_MO_EXTRA_FIRST 76
`define MRVIO_MO_EXTRA_LAST  79

// Register addresses seen by the serial engine
`define MRVIO_ADDR_STATE0    8'h3c
`define MRVIO_ADDR_VIN_LO    8'h3e
`define MRVIO_ADDR_VIN_HI    8'h3f
`define MRVIO_ADDR_STATE7    8'h43

// Field positions inside the virtual input registers
`define MRVIO_VIN_LO_B8      6
`define MRVIO_VIN_LO_B9      7

// Reset values and the value read at unmapped addresses
`define MRVIO_VIN_RST        10'h000
`define MRVIO_RDATA_RST      8'h00
`define MRVIO_UNMAPPED_RD    8'h00

`endif

// [hw/mrvio_sel.v]
// One matrix output: a 64-way selector driven by a 6-bit field.
// Assumes the field is static configuration and the lines are levels.
`include "mrvio_defs.vh"

module mrvio_sel (
	input  wire [`MRVIO_NUM_LINES-1:0] lines,
	input  wire [`MRVIO_SEL_W-1:0]     sel,
	output wire                        y
);

	// Pure combinational path, no flop in the route
	assign y = lines[sel];

endmodule // mrvio_sel

// [hw/mrvio_top.v]
// Upper connection matrix outputs (12..79) and the virtual I/O registers.
// Assumes a serial engine that presents decoded register strobes in the
// core_clk domain, and NVM contents that are stable after startup.
//
// Functional notes
// [R1] Output N selects its source with configuration field bits 6N+5..6N.
// [R2] Field value is the matrix input number, 0 is ground, 63 is supply.
// [R3] Outputs follow the selected input combinationally, no register stage.
// [R4] Outputs 76 to 79 exist only in the 24-pin variant.
// [R5] GPIO0 to GPIO3 each get a routed data output and output enable.
// [R6] Routed outputs drive peripheral controls such as rheostat reloads.
// [R7] Pattern generator clock and reset come from outputs 68 and 69.
// [R8] Ten matrix inputs are virtual, driven by host-writable bits.
// [R9] Virtual inputs are read and written at addresses virtual_input_low and virtual_input_high.
// [R10] A write to a virtual bit changes the matrix level at once.
// [R11] Reads return the NVM startup value until written, then the last write.
// [R12] Virtual inputs 0..7 sit in bits 504..511 and feed inputs 24..31.
// [R13] Virtual 8 and 9 sit in bits 502, 503, feed inputs 22, 23.
// [R14] Macrocell output states read back at addresses macrocell_state_0 to macrocell_state_7.
// [R15] Writes to state registers are ignored except at virtual_input_low and virtual_input_high.
`include "mrvio_defs.vh"

module mrvio_top (
	input  wire           core_clk,
	input  wire           reset_n,
	// Startup configuration
	input  wire           pkg24_strap,
	input  wire           vin89_avail,
	input  wire           nvm_load,
	input  wire [511:502] nvm_vin_init,
	input  wire [479:72]  cfg_matrix,
	// Macrocell outputs entering the matrix
	input  wire [63:0]    macro_src,
	// Register port from the serial engine
	input  wire [7:0]     reg_addr,
	input  wire           reg_wr,
	input  wire           reg_rd,
	input  wire [7:0]     reg_wdata,
	output reg  [7:0]     reg_rdata,
	output reg            reg_rvalid,
	// Logic cell, counter and delay inputs (outputs 12..47)
	output wire [47:12]   cell_in,
	output wire           pdly_in,
	output wire           od_sda_general_output,
	output wire           od_scl_general_output,
	output wire           gpio0_out,
	output wire           gpio0_oe,
	output wire           gpio1_out,
	output wire           gpio1_oe,
	output wire           gpio2_out,
	output wire           gpio2_oe,
	output wire           gpio3_out,
	output wire           gpio3_oe,
	output wire           sink_source_buf_en,
	output wire           opamp_vref_en,
	output wire           rheo0_updown,
	output wire           rheo1_updown,
	output wire           analog_switch_en,
	output wire           opamp0_en,
	output wire           opamp1_en,
	output wire           multichannel_sampling_comparator_en,
	output wire           multichannel_sampling_comparator_latch_rst_n,
	output wire           osc0_en,
	output wire           pattern_generator_clk,
	output wire           pattern_generator_rst_n,
	output wire           rheo0_clk,
	output wire           rheo0_reload,
	output wire           rheo1_clk,
	output wire           rheo1_reload,
	output wire           osc1_en,
	output wire           multichannel_sampling_comparator_external_clock_input,
	output wire           gpio6_out,
	output wire           gpio7_out,
	output wire           gpio8_out,
	output wire           gpio9_out
);

	// Virtual input bits, indexed by configuration bit position
	reg  [511:502] vin_q;
	reg  [511:502] vin_d;
	reg            pkg24_q;
	reg  [7:0]     rdata_d;

	wire [63:0]    mi;
	wire [79:12]   mo_raw;
	wire [79:12]   mo;
	wire           wr_vin_lo;
	wire           wr_vin_hi;
	wire           rd_hit;

	// Decode of the readable window, used for read data only; validity follows reg_rd
	function addr_in_state;
		input [7:0] a;
		begin
			addr_in_state = (a >= `MRVIO_ADDR_STATE0) &&
				(a <= `MRVIO_ADDR_STATE7);
		end
	endfunction

	// Byte k of the 64 matrix lines, with the virtual bits taken from
	// the registers so a read shows what software last wrote.
	function [7:0] state_byte;
		input [7:0]   a;
		input [63:0]  lines;
		input [511:502] v;
		reg   [7:0]   off;
		begin
			off = a - `MRVIO_ADDR_STATE0;
			case (off)
				8'h00: state_byte = lines[7:0];
				8'h01: state_byte = lines[15:8];
				8'h02: state_byte = {v[503], v[502], lines[21:16]};
				8'h03: state_byte = v[511:504];
				8'h04: state_byte = lines[39:32];
				8'h05: state_byte = lines[47:40];
				8'h06: state_byte = lines[55:48];
				8'h07: state_byte = lines[63:56];
				default: state_byte = `MRVIO_UNMAPPED_RD;
			endcase
		end
	endfunction

	// Matrix input lines: hard ground and supply at the ends, virtual bits
	// overriding their macrocell sources.
	assign mi[`MRVIO_MI_GND] = 1'b0; // see [R2]
	assign mi[21:1]          = macro_src[21:1];
	// Pins 22/23 only become virtual when the serial pins are free
	assign mi[`MRVIO_MI_VIN8] = vin89_avail ? vin_q[`MRVIO_CFG_VIN8_BIT]
		: macro_src[`MRVIO_MI_VIN8]; // see [R13]
	assign mi[`MRVIO_MI_VIN9] = vin89_avail ? vin_q[`MRVIO_CFG_VIN9_BIT]
		: macro_src[`MRVIO_MI_VIN9]; // see [R13]
	assign mi[`MRVIO_MI_VIN7:`MRVIO_MI_VIN0] =
		vin_q[`MRVIO_CFG_VIN7_BIT:`MRVIO_CFG_VIN0_BIT]; // see [R8] [R12]
	assign mi[62:32]          = macro_src[62:32];
	assign mi[`MRVIO_MI_VDD]  = 1'b1; // see [R2]

	// One selector per matrix output, field at bits 6N+5..6N
	genvar n;
	generate
		for (n = `MRVIO_OUT_FIRST; n <= `MRVIO_OUT_LAST; n = n + 1)
		begin : g_route
			mrvio_sel u_sel (
				.lines (mi),
				.sel   (cfg_matrix[6*n+5:6*n]), // see [R1] [R2]
				.y     (mo_raw[n])              // see [R3]
			);
		end
	endgenerate

	// Extra GPIO outputs are held low on the smaller package; the
	// strap is caught with the NVM load, never under the async reset.
	assign mo[75:12] = mo_raw[75:12];
	assign mo[`MRVIO_MO_EXTRA_LAST:`MRVIO_MO_EXTRA_FIRST] = pkg24_q ?
		mo_raw[`MRVIO_MO_EXTRA_LAST:`MRVIO_MO_EXTRA_FIRST] :
		4'h0; // see [R4]

	// Logic cells, counters, delays
	assign cell_in = mo[47:12];
	// Delay input shares matrix output 47 with the last cell input
	assign pdly_in = mo[47];

	// Pin outputs
	assign od_sda_general_output = mo[48];
	assign od_scl_general_output = mo[49];
	assign gpio0_out = mo[50]; // see [R5]
	assign gpio0_oe  = mo[51]; // see [R5]
	assign gpio1_out = mo[52]; // see [R5]
	assign gpio1_oe  = mo[53]; // see [R5]
	assign gpio2_out = mo[54]; // see [R5]
	assign gpio2_oe  = mo[55]; // see [R5]
	assign gpio3_out = mo[56]; // see [R5]
	assign gpio3_oe  = mo[57]; // see [R5]

	// Analog and peripheral controls, then the extra GPIO outputs
	assign sink_source_buf_en = mo[58];
	assign opamp_vref_en      = mo[59];
	assign rheo0_updown       = mo[60]; // see [R6]
	assign rheo1_updown       = mo[61]; // see [R6]
	assign analog_switch_en   = mo[62];
	assign opamp0_en          = mo[63];
	assign opamp1_en          = mo[64];
	assign multichannel_sampling_comparator_en          = mo[65];
	assign multichannel_sampling_comparator_latch_rst_n = mo[66];
	assign osc0_en                 = mo[67];
	assign pattern_generator_clk   = mo[68]; // see [R7]
	assign pattern_generator_rst_n = mo[69]; // see [R7]
	assign rheo0_clk               = mo[70]; // see [R6]
	assign rheo0_reload            = mo[71]; // see [R6]
	assign rheo1_clk               = mo[72]; // see [R6]
	assign rheo1_reload            = mo[73]; // see [R6]
	assign osc1_en                 = mo[74];
	assign multichannel_sampling_comparator_external_clock_input = mo[75];
	assign gpio6_out = mo[76]; // see [R4]
	assign gpio7_out = mo[77]; // see [R4]
	assign gpio8_out = mo[78]; // see [R4]
	assign gpio9_out = mo[79]; // see [R4]

	// Register writes: only the two virtual input bytes take data
	assign wr_vin_lo = reg_wr && (reg_addr == `MRVIO_ADDR_VIN_LO); // see [R9]
	assign wr_vin_hi = reg_wr && (reg_addr == `MRVIO_ADDR_VIN_HI); // see [R9]
	assign rd_hit    = addr_in_state(reg_addr); // see [R14]

	always @* begin
		vin_d = vin_q;
		// Startup load first, so a write in the same cycle still lands
		if (nvm_load) begin
			vin_d = nvm_vin_init; // see [R11]
		end
		if (wr_vin_hi) begin
			vin_d[`MRVIO_CFG_VIN7_BIT:`MRVIO_CFG_VIN0_BIT] =
				reg_wdata; // see [R10] [R12]
		end
		// Only bits 7:6 of the low byte are writable; the rest of the
		// byte reflects macrocell state and ignores the write.
		if (wr_vin_lo) begin
			vin_d[`MRVIO_CFG_VIN8_BIT] =
				reg_wdata[`MRVIO_VIN_LO_B8]; // see [R13] [R15]
			vin_d[`MRVIO_CFG_VIN9_BIT] =
				reg_wdata[`MRVIO_VIN_LO_B9]; // see [R13] [R15]
		end
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			vin_q   <= `MRVIO_VIN_RST;
			pkg24_q <= 1'b0;
		end else begin
			vin_q <= vin_d; // see [R10]
			if (nvm_load) begin
				pkg24_q <= pkg24_strap;
			end
		end
	end

	// Read data: state bytes, unmapped addresses read as zero
	always @* begin
		rdata_d = `MRVIO_UNMAPPED_RD;
		if (rd_hit) begin
			rdata_d = state_byte(reg_addr, mi, vin_q); // see [R11] [R14]
		end
	end

	// Read answer one cycle after the strobe, held until the next read
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata  <= `MRVIO_RDATA_RST;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_d; // see [R9] [R14]
			end
		end
	end

endmodule // mrvio_top

// [tb/mrvio_host.sv]
// Host side model: issues register reads and writes to the block.
// Assumes the bench calls its tasks and drives inputs at falling edges.
module mrvio_host (
	input  wire       core_clk,
	input  wire [7:0] reg_rdata,
	input  wire       reg_rvalid,
	output logic [7:0] reg_addr,
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [7:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// One-cycle strobe; writes get no answer back
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// Answer stands one cycle, so it is taken at the first low edge seen
	task rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(negedge core_clk);
		{reg_addr, reg_rd} = {a, 1'b1};
		@(negedge core_clk);
		reg_rd = 1'b0;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(negedge core_clk);
			n++;
		end
		d = reg_rdata;
		if (n == 4) begin
			tb_mrvio_top.err_total++;
			tb_mrvio_top.complete_run();
		end
	endtask
endmodule // mrvio_host

// [tb/mrvio_top_asserts.sv]
// Port-level checks of the routing block and its register port.
// Assumes a single core_clk domain; bound into every mrvio_top.
module mrvio_chk (
	input wire           core_clk,
	input wire           reset_n,
	input wire           nvm_load,
	input wire [479:72]  cfg_matrix,
	input wire [63:0]    macro_src,
	input wire [7:0]     reg_addr,
	input wire           reg_wr,
	input wire           reg_rd,
	input wire [7:0]     reg_wdata,
	input wire [7:0]     reg_rdata,
	input wire           reg_rvalid,
	input wire           gpio0_out,
	input wire           gpio0_oe,
	input wire           pattern_generator_clk,
	input wire           rheo0_reload
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	rd_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read gave no answer");
	no_spare_a: assert property (!reg_rd |=> !reg_rvalid)
		else $error("answer without read");
	state_rd_a: assert property (reg_rd && reg_addr == 8'h40
		|=> reg_rdata == $past(macro_src[39:32])) else $error("state wrong");
	unmapped_rd_a: assert property (reg_rd && (reg_addr < 8'h3c ||
		reg_addr > 8'h43) |=> reg_rdata == 8'h00) else $error("unmapped");
	vin_rdback_a: assert property (reg_wr && reg_addr == 8'h3f && !nvm_load
		##1 !reg_wr ##1 reg_rd && reg_addr == 8'h3f && !reg_wr
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("readback");
	vin_route_a: assert property (reg_wr && reg_addr == 8'h3f &&
		cfg_matrix[305:300] == 6'h18 |=> gpio0_out == $past(reg_wdata[0]))
		else $error("virtual input not routed");
	gnd_sel_a: assert property (cfg_matrix[305:300] == 6'h00 |-> !gpio0_out)
		else $error("ground select");
	vdd_oe_a: assert property (cfg_matrix[311:306] == 6'h3f |-> gpio0_oe)
		else $error("supply select");
	pgen_clk_a: assert property (cfg_matrix[413:408] == 6'h3f
		|-> pattern_generator_clk) else $error("pattern clock");
	reload_gnd_a: assert property (cfg_matrix[431:426] == 6'h00
		|-> !rheo0_reload) else $error("reload select");
endmodule // mrvio_chk

bind mrvio_top mrvio_chk chk_u (.core_clk(core_clk), .reset_n(reset_n),
	.nvm_load(nvm_load), .cfg_matrix(cfg_matrix), .macro_src(macro_src),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.gpio0_out(gpio0_out), .gpio0_oe(gpio0_oe), .rheo0_reload(rheo0_reload),
	.pattern_generator_clk(pattern_generator_clk));

// [tb/tb_mrvio_top.sv]
// Self-checking bench of mrvio_top with the host model on its port.
// Assumes the design files and the checker are compiled before it.
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_mrvio_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, reset_n = 0, pkg24_strap = 0, vin89_avail = 0;
	logic nvm_load = 0;
	logic [511:502] nvm_vin_init = 10'h2b6;
	logic [479:72]  cfg_matrix = 408'h0;
	logic [63:0]    macro_src = 64'h5a3c_9612_f0e1_c3a7;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire reg_wr, reg_rd, reg_rvalid;
	wire [79:12] mo;
	wire         pdly;
	logic [7:0] d;
	int err_total = 0, checked = 0;
	always #2.5 core_clk = ~core_clk;
	mrvio_top dut_u (.core_clk(core_clk), .reset_n(reset_n),
		.pkg24_strap(pkg24_strap), .vin89_avail(vin89_avail),
		.nvm_load(nvm_load), .nvm_vin_init(nvm_vin_init),
		.cfg_matrix(cfg_matrix), .macro_src(macro_src), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cell_in(mo[47:12]),
		.pdly_in(pdly), .od_sda_general_output(mo[48]),
		.od_scl_general_output(mo[49]), .gpio0_out(mo[50]), .gpio0_oe(mo[51]),
		.gpio1_out(mo[52]), .gpio1_oe(mo[53]), .gpio2_out(mo[54]),
		.gpio2_oe(mo[55]), .gpio3_out(mo[56]), .gpio3_oe(mo[57]),
		.sink_source_buf_en(mo[58]), .opamp_vref_en(mo[59]),
		.rheo0_updown(mo[60]), .rheo1_updown(mo[61]),
		.analog_switch_en(mo[62]), .opamp0_en(mo[63]), .opamp1_en(mo[64]),
		.multichannel_sampling_comparator_en(mo[65]),
		.multichannel_sampling_comparator_latch_rst_n(mo[66]),
		.osc0_en(mo[67]), .pattern_generator_clk(mo[68]),
		.pattern_generator_rst_n(mo[69]), .rheo0_clk(mo[70]),
		.rheo0_reload(mo[71]), .rheo1_clk(mo[72]), .rheo1_reload(mo[73]),
		.osc1_en(mo[74]), .multichannel_sampling_comparator_external_clock_input(mo[75]),
		.gpio6_out(mo[76]), .gpio7_out(mo[77]), .gpio8_out(mo[78]),
		.gpio9_out(mo[79]));
	mrvio_host host_u (.core_clk(core_clk), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata));
	task complete_run;
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task sel(input int n, input logic [5:0] v);
		cfg_matrix[6*n +: 6] = v;
		#1;
	endtask
	task load(input logic pkg);
		@(negedge core_clk);
		{pkg24_strap, nvm_load} = {pkg, 1'b1};
		@(negedge core_clk);
		nvm_load = 1'b0;
	endtask
	task t_nvm;
		host_u.rd(8'h3f, d);
		`CHK("vin before load", 8'h00, d)
		load(1'b1);
		host_u.rd(8'h3f, d);
		`CHK("vin 0..7 loaded", nvm_vin_init[511:504], d)
		host_u.rd(8'h3e, d);
		`CHK("vin 8,9 loaded", {nvm_vin_init[503:502], macro_src[21:16]}, d)
		$display("t_nvm done");
	endtask
	task t_vin;
		sel(50, 6'h18);
		host_u.wr(8'h3f, 8'ha5);
		for (int k = 0; k < 8; k++) begin
			sel(50, 6'h18 + k);
			`CHK("virtual line", 8'ha5 >> k & 8'h01, {7'h00, mo[50]})
		end
		host_u.rd(8'h3f, d);
		`CHK("vin 0..7 readback", 8'ha5, d)
		host_u.wr(8'h3e, 8'h7f);
		vin89_avail = 1'b1;
		sel(50, 6'h16);
		`CHK("vin8 line", 1'b1, mo[50])
		sel(50, 6'h17);
		`CHK("vin9 line", 1'b0, mo[50])
		vin89_avail = 1'b0;
		#1;
		`CHK("pin in place of vin9", macro_src[23], mo[50])
		host_u.rd(8'h3e, d);
		`CHK("vin 8,9 readback", {2'b01, macro_src[21:16]}, d)
		sel(50, 6'h00);
		$display("t_vin done");
	endtask
	task t_ro;
		host_u.wr(8'h40, 8'hff);
		host_u.wr(8'h3c, 8'hff);
		host_u.rd(8'h40, d);
		`CHK("state macrocell_state_4", macro_src[39:32], d)
		host_u.rd(8'h3c, d);
		`CHK("state macrocell_state_0", {macro_src[7:1], 1'b0}, d)
		host_u.rd(8'h43, d);
		`CHK("state macrocell_state_7", {1'b1, macro_src[62:56]}, d)
		host_u.rd(8'h44, d);
		`CHK("unmapped 0x44", 8'h00, d)
		host_u.rd(8'h3b, d);
		`CHK("unmapped 0x3b", 8'h00, d)
		$display("t_ro done");
	endtask
	task t_map;
		for (int n = 12; n < 80; n++) begin
			sel(n, 6'h3f);
			`CHK("one output high", 68'h1 << (n - 12), mo)
			`CHK("delay input", (n == 47), pdly)
			sel(n, 6'h00);
		end
		for (int k = 32; k < 63; k++) begin
			sel(12, k[5:0]);
			`CHK("decoded source", macro_src[k], mo[12])
		end
		sel(12, 6'h00);
		load(1'b0);
		sel(79, 6'h3f);
		`CHK("extra gpio in small part", 1'b0, mo[79])
		sel(79, 6'h00);
		$display("t_map done");
	endtask
	initial begin
		repeat (4) @(negedge core_clk);
		reset_n = 1'b1;
		t_nvm();
		t_vin();
		t_ro();
		t_map();
		complete_run();
	end
endmodule // tb_mrvio_top
